// file: verilog/mbag_pkg.sv
// Package: constants and types for the modulo / bit-reverse address generator
package mbag_pkg;
   localparam int AW = 16;
   localparam int WREG_W = 4;
   localparam logic [3:0] STACK_PTR_SEL = 4'hF;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam int BRV_EN_BIT = 15;
   localparam int BRV_MOD_MSB = 14;
   // Addressing modes presented by decode
   typedef enum logic [2:0] {
      MBAG_IND     = 3'h0,
      MBAG_POSTINC = 3'h1,
      MBAG_POSTDEC = 3'h2,
      MBAG_PREINC  = 3'h3,
      MBAG_PREDEC  = 3'h4,
      MBAG_REGOFS  = 3'h5
   } mbag_mode_t;
endpackage

// file: verilog/mbag_bitrev_add.sv
// Bit-reversed modifier adder for the X write unit
`timescale 1ns/1ns
module mbag_bitrev_add #(
   parameter int AW = 16
) (
   input  wire logic [AW-1:0] ptr,
   input  wire logic [AW-2:0] modifier,
   output logic      [AW-1:0] sum
);
   // ------------------------------------------------------------
   // Reverse-carry add
   // ------------------------------------------------------------
   function automatic logic [AW-2:0] rev(input logic [AW-2:0] v);
      logic [AW-2:0] r;
      r = '0;
      for (int i = 0; i < AW-1; i++)
         r[i] = v[AW-2-i];
      return r;
   endfunction

   logic [AW-2:0] wptr;
   logic [AW-2:0] wmod;
   logic [AW-2:0] rsum;
   logic [AW-2:0] wsum;
   assign wptr = ptr[AW-1:1];
   // Modifier counts bytes; its bit 0 means nothing for word steps
   assign wmod = {1'b0, modifier[AW-2:1]};
   // Pointer and result kept in normal order, only carries flow reversed
   // Carry out past the lowest word bit is dropped on purpose
   assign rsum = rev(wptr) + rev(wmod);
   assign wsum = rev(rsum);
   assign sum  = {wsum, 1'b0};
endmodule // mbag_bitrev_add

// file: verilog/mbag_core.sv
// Effective-address generator with modulo wrap and bit-reversed writes
// Notes on behaviour
// RULE1: Modulo correction usable with any pointer register
// RULE2: Incrementing buffer checks upper boundary
// RULE3: Decrementing buffer checks lower boundary
// RULE4: Overshoot past boundary is also detected
// RULE5: Write back only for pre/post modify
// RULE6: Register offset mode wraps, pointer untouched
// RULE7: Bit reverse only X unit writes
// RULE8: Modifier treated as bit-reversed when adding
// RULE9: Pointer and result stay in normal order
// RULE10: Enable set, pointer not stack, pre/post increment
// RULE11: Enable bit lives in bit-reverse control
// RULE12: Add reversed modifier, drop offset, clear LSB
// RULE13: Byte writes or other modes use normal addressing
// RULE14: Wrap by buffer length past opposite boundary
`timescale 1ns/1ns
module mbag_core #(
   parameter int AW = mbag_pkg::AW
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 req,
   input  wire logic                 is_x_unit,
   input  wire logic                 is_write,
   input  wire logic                 is_byte,
   input  wire logic [2:0]           mode,
   input  wire logic [3:0]           ptr_sel,
   input  wire logic [AW-1:0]        ptr_val,
   input  wire logic [AW-1:0]        offset,
   input  wire logic                 modulo_enable,
   input  wire logic [3:0]           modulo_ptr_sel,
   input  wire logic [AW-1:0]        buf_start,
   input  wire logic [AW-1:0]        buf_end,
   input  wire logic [3:0]           bit_reverse_pointer_select,
   input  wire logic [15:0]          bit_reverse_control_reg,
   output logic                      ea_valid,
   output logic [AW-1:0]             effective_address,
   output logic                      wb_en,
   output logic [3:0]                wb_sel,
   output logic [AW-1:0]             wb_value,
   output logic                      brev_used
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   mbag_pkg::mbag_mode_t m;
   logic          inc_mode;
   logic          dec_mode;
   logic          pre_mode;
   logic          modify;
   logic [AW-1:0] raw_ea;
   logic [AW-1:0] new_ptr;
   logic [AW-1:0] chk;
   logic [AW-1:0] len;
   logic          mod_on;
   logic          over;
   logic          under;
   logic [AW-1:0] fixed;
   logic          brev_on;
   logic          bit_reverse_enable;
   logic [AW-1:0] brev_sum;
   logic [AW-1:0] next_ea;
   logic [AW-1:0] next_ptr;

   assign m = mbag_pkg::mbag_mode_t'(mode);
   assign inc_mode = (m == mbag_pkg::MBAG_POSTINC)
                   || (m == mbag_pkg::MBAG_PREINC);
   assign dec_mode = (m == mbag_pkg::MBAG_POSTDEC)
                   || (m == mbag_pkg::MBAG_PREDEC);
   assign pre_mode = (m == mbag_pkg::MBAG_PREINC)
                   || (m == mbag_pkg::MBAG_PREDEC);
   assign modify = inc_mode || dec_mode;

   // ------------------------------------------------------------
   // Modulo path
   // ------------------------------------------------------------
   // Step is scaled by access size; offset mode adds the register
   always_comb
   begin
      new_ptr = ptr_val;
      if (inc_mode)
         new_ptr = ptr_val + (is_byte ? AW'(1) : AW'(2));
      else if (dec_mode)
         new_ptr = ptr_val - (is_byte ? AW'(1) : AW'(2));
      if (m == mbag_pkg::MBAG_REGOFS)
         raw_ea = ptr_val + offset;
      else if (pre_mode)
         raw_ea = new_ptr;
      else
         raw_ea = ptr_val;
   end

   // Any register may be the modulo pointer, set by its select field
   assign mod_on = modulo_enable && (ptr_sel == modulo_ptr_sel); // RULE1
   assign len = AW'(buf_end - buf_start + AW'(1));
   // Check the value that advances; post forms check the new pointer
   assign chk = (m == mbag_pkg::MBAG_REGOFS || pre_mode) ? raw_ea : new_ptr;
   assign over  = (chk > buf_end); // RULE2 RULE4
   assign under = (chk < buf_start); // RULE3 RULE4

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a,
                                          input logic          hi,
                                          input logic          lo);
      if (hi)
         return a - len; // RULE14
      else if (lo)
         return a + len; // RULE14
      else
         return a;
   endfunction

   always_comb
   begin
      fixed = raw_ea;
      next_ptr = new_ptr;
      if (mod_on)
      begin
         if (m == mbag_pkg::MBAG_REGOFS)
            fixed = wrap(raw_ea, over, under); // RULE6
         else if (inc_mode)
            next_ptr = wrap(new_ptr, over, 1'b0); // RULE2
         else if (dec_mode)
            next_ptr = wrap(new_ptr, 1'b0, under); // RULE3
         if (pre_mode)
            fixed = next_ptr;
      end
   end

   // ------------------------------------------------------------
   // Bit-reversed path
   // ------------------------------------------------------------
   assign bit_reverse_enable =
      bit_reverse_control_reg[mbag_pkg::BRV_EN_BIT]; // RULE11
   // Takes precedence over modulo for qualifying writes
   assign brev_on = bit_reverse_enable
      && (bit_reverse_pointer_select != mbag_pkg::STACK_PTR_SEL) // RULE10
      && (ptr_sel == bit_reverse_pointer_select)
      && is_x_unit && is_write // RULE7
      && !is_byte && inc_mode; // RULE13

   mbag_bitrev_add #(
      .AW       (AW)
   ) u_brev (
      .ptr      (ptr_val), // RULE9
      .modifier (bit_reverse_control_reg[mbag_pkg::BRV_MOD_MSB:0]), // RULE8
      .sum      (brev_sum) // RULE12
   );

   assign next_ea = brev_on ? (pre_mode ? brev_sum : ptr_val & ~AW'(1))
                            : fixed;

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ea_valid <= 1'b0;
         effective_address <= mbag_pkg::RST_ADDR;
         brev_used <= 1'b0;
      end
      else
      begin
         ea_valid <= req;
         brev_used <= req && brev_on;
         if (req)
            effective_address <= next_ea; // RULE12
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wb_en <= 1'b0;
         wb_sel <= 4'h0;
         wb_value <= mbag_pkg::RST_ADDR;
      end
      else
      begin
         wb_en <= req && modify; // RULE5 RULE6
         if (req)
         begin
            wb_sel <= ptr_sel;
            wb_value <= brev_on ? brev_sum : next_ptr;
         end
      end
   end
endmodule // mbag_core

// file: test/mbag_checker.sv
// Assertion checker for the address generator ports
`timescale 1ns/1ns
module mbag_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        req,
   input wire logic        is_x_unit,
   input wire logic        is_write,
   input wire logic        is_byte,
   input wire logic [2:0]  mode,
   input wire logic [3:0]  ptr_sel,
   input wire logic [3:0]  bit_reverse_pointer_select,
   input wire logic [15:0] bit_reverse_control_reg,
   input wire logic        ea_valid,
   input wire logic [15:0] effective_address,
   input wire logic        wb_en,
   input wire logic        brev_used
);
   logic inc;
   logic brv;
   assign inc = mode inside {3'h1, 3'h3};
   assign brv = req && is_x_unit && is_write && !is_byte && inc &&
      bit_reverse_control_reg[15] && ptr_sel != 4'hF &&
      ptr_sel == bit_reverse_pointer_select;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   brev_taken_a:
      assert property (brv |=> brev_used) else $error("no bit reverse");
   brev_stack_a:
      assert property (req && bit_reverse_pointer_select == 4'hF
         |=> !brev_used) else $error("stack pointer reversed");
   brev_off_a:
      assert property (req && !bit_reverse_control_reg[15] |=> !brev_used)
         else $error("reversed while disabled");
   read_plain_a:
      assert property (req && !(is_x_unit && is_write) |=> !brev_used)
         else $error("reversed on read or y unit");
   byte_plain_a:
      assert property (req && (is_byte || !inc) |=> !brev_used)
         else $error("reversed on byte or mode");
   brev_lsb_a:
      assert property (brev_used |-> !effective_address[0] && ea_valid)
         else $error("reversed address odd");
   modify_wb_a:
      assert property (req && mode inside {3'h1, 3'h2, 3'h3, 3'h4}
         |=> wb_en && ea_valid ##1 !wb_en || $past(req))
         else $error("write back missing");
   offset_no_wb_a:
      assert property (req && mode inside {3'h0, 3'h5} |=> !wb_en)
         else $error("write back without modify");
   cover property (brev_used);
   cover property (wb_en ##1 wb_en);
   cover property (req && mode == 3'h5 ##1 ea_valid);
endmodule // mbag_checker

bind mbag_core mbag_checker u_mbag_checker (.*);

// file: test/mbag_regfile.sv
// Working register file model that feeds pointers to the block
`timescale 1ns/1ns
module mbag_regfile (
   input  wire logic        clk,
   input  wire logic        wb_en,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [15:0] wb_value,
   input  wire logic [3:0]  ptr_sel,
   output logic      [15:0] ptr_val
);
   logic [15:0] regs [16];
   initial
      for (int i = 0; i < 16; i++)
         regs[i] = 16'h1000 + 16'(i & 14);
   // Bypass, so a request right after a write-back sees the new pointer
   assign ptr_val = wb_en && wb_sel == ptr_sel ? wb_value : regs[ptr_sel];
   always @(posedge clk)
      if (wb_en)
         regs[wb_sel] <= wb_value;
endmodule // mbag_regfile

// file: test/test_modulo_bitrev_address_gen.sv
// Random self-checking bench for the address generator
`timescale 1ns/1ns
module test_modulo_bitrev_address_gen;
   logic        clk = 0, rst = 1, req = 0, is_x_unit = 0, is_write = 0;
   logic        is_byte = 0, modulo_enable = 0, ea_valid, wb_en, brev_used;
   logic        e_v = 0, e_wb = 0, e_br = 0;
   logic [2:0]  mode = 0;
   logic [3:0]  ptr_sel = 0, modulo_ptr_sel = 0, wb_sel, e_sel;
   logic [3:0]  bit_reverse_pointer_select = 0;
   logic [15:0] ptr_val, effective_address, wb_value, s, p, e_ea;
   logic [15:0] offset = 0, bit_reverse_control_reg = 0;
   logic [15:0] buf_start = 16'h1000, buf_end = 16'h100F;
   int          seed = 95, n_mismatch = 0, checked = 0, cyc = 0;

   mbag_core u_mbag_core (.*);
   mbag_regfile u_mbag_regfile (.*);

   always #2 clk = ~clk;
   always @(posedge clk)
      if (++cyc == 3000)
      begin
         n_mismatch++;
         wrap_up;
      end

   function automatic logic [15:0] rv(input logic [15:0] a);
      logic [15:0] r;
      for (int i = 0; i < 16; i++)
         r[i] = a[15 - i];
      return r;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Inputs read at the taking edge, before that edge's updates land
   task automatic predict;
      logic up, dn, br;
      up = mode inside {3'h1, 3'h3, 3'h5};
      dn = mode inside {3'h2, 3'h4, 3'h5};
      br = is_x_unit && is_write && !is_byte && mode inside {3'h1, 3'h3} &&
         bit_reverse_control_reg[15] && ptr_sel != 4'hF &&
         ptr_sel == bit_reverse_pointer_select;
      p = is_byte ? 16'h1 : 16'h2;
      s = mode == 3'h5 ? ptr_val + offset : dn ? ptr_val - p :
         up ? ptr_val + p : ptr_val;
      if (modulo_enable && modulo_ptr_sel == ptr_sel)
      begin
         p = buf_end - buf_start + 16'h1;
         if (up && s > buf_end) s -= p;
         if (dn && s < buf_start) s += p;
      end
      e_ea = mode inside {3'h3, 3'h4, 3'h5} ? s : ptr_val;
      if (br)
      begin
         p = rv(ptr_val & 16'hFFFE) + rv(bit_reverse_control_reg & 16'h7FFE);
         s = rv(p) & 16'hFFFE;
         e_ea = mode == 3'h3 ? s : ptr_val & 16'hFFFE;
      end
      e_v = req;
      e_wb = req && mode inside {3'h1, 3'h2, 3'h3, 3'h4};
      e_br = req && br;
      e_sel = ptr_sel;
   endtask

   // Early cycles force X writes with modulo on to crowd the wrap cases
   // Every 50th cycle: word pre-increment X write, modulo on, reversed unless ptr_sel is 4'hF
   task automatic drive;
      logic [3:0] r;
      logic       c;
      r = 4'($random(seed));
      c = cyc % 50 == 0;
      req <= c || $random(seed) % 4 != 0;
      mode <= c ? 3'h3 : 3'($unsigned($random(seed)) % 6);
      {is_x_unit, is_write, modulo_enable} <=
         3'($random(seed)) | {3{cyc < 700 || c}};
      is_byte <= !c && $random(seed) % 4 == 0;
      ptr_sel <= r;
      modulo_ptr_sel <= $random(seed) % 2 ? r : r + 4'h1;
      bit_reverse_pointer_select <= c || $random(seed) % 4 ? r : 4'hF;
      bit_reverse_control_reg <=
         (16'($random(seed)) & 16'h801E) | {c, 15'h0010};
      offset <= 16'($random(seed) % 15);
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (2000)
      begin
         @(posedge clk);
         chk(16'(ea_valid), 16'(e_v));
         chk(16'(wb_en), 16'(e_wb));
         chk(16'(brev_used), 16'(e_br));
         if (e_v) chk(effective_address, e_ea);
         if (e_wb) chk(wb_value, s);
         if (e_wb) chk(16'(wb_sel), 16'(e_sel));
         predict;
         drive;
      end
      wrap_up;
   end
endmodule // test_modulo_bitrev_address_gen
